/* fels_flash_model.sv */
`timescale 1ns/1ps
module fels_flash_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       valid,
  input  wire logic [7:0] dly,
  input  wire logic       fail,
  output logic            ack,
  output logic            verify_fail
);
  logic [7:0] cnt;
  logic       tgl;
  // busy counter, one ack pulse per request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 8'h00;
      ack <= 1'b0;
      tgl <= 1'b0;
    end else begin
      tgl <= !tgl;
      ack <= 1'b0;
      if (valid && !ack) begin
        if (cnt >= dly) begin
          ack <= 1'b1;
          cnt <= 8'h00;
        end else begin
          cnt <= cnt + 8'h01;
        end
      end
    end
  end
  assign verify_fail = ack ? fail : tgl; // junk outside the pulse
endmodule

/* fels_irq_unit.sv */
`timescale 1ns/1ps
module fels_irq_unit
  import fels_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [NUM_EV-1:0] set_ev,
  input  wire logic              clr_wr,
  input  wire logic [NUM_EV-1:0] clr_bits,
  input  wire logic              mask_wr,
  input  wire logic [NUM_EV-1:0] mask_bits,
  input  wire logic [NUM_EV-1:0] gate,
  output logic      [NUM_EV-1:0] status,
  output logic      [NUM_EV-1:0] mask,
  output logic                   irq
);

  fels_irq_t s;
  fels_irq_t next_s;

  // write-one-to-clear, a new event wins over the clear
  always_comb begin
    next_s = s;
    if (clr_wr) begin
      next_s.status = s.status & ~clr_bits;
    end
    next_s.status = next_s.status | set_ev;
    if (mask_wr) begin
      next_s.mask = mask_bits;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // level request while any enabled sticky bit stands
  assign status = s.status;
  assign mask   = s.mask;
  assign irq    = |(s.status & s.mask & gate);

endmodule

/* fels_lock_check.sv */
`timescale 1ns/1ps
module fels_lock_check
  import fels_pkg::*;
#(
  parameter int REGION_SHIFT = 5
) (
  input  wire logic [NUM_REGIONS-1:0] lock,
  input  wire logic [PAGE_W-1:0]      first_page,
  input  wire logic [PAGE_W-1:0]      last_page,
  output logic                        hit
);

  // any locked region overlapping the page span
  always_comb begin
    logic [PAGE_W-1:0] first_r;
    logic [PAGE_W-1:0] last_r;
    first_r = first_page >> REGION_SHIFT;
    last_r  = last_page >> REGION_SHIFT;
    hit     = 1'b0;
    for (int i = 0; i < NUM_REGIONS; i++) begin
      if (lock[i] && (PAGE_W'(i) >= first_r) && (PAGE_W'(i) <= last_r)) begin
        hit = 1'b1;
      end
    end
  end

endmodule

/* fels_pkg.sv */
package fels_pkg;

  // bus and array widths
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 32;
  localparam int STRB_W      = 4;
  localparam int PAGE_W      = 16;
  localparam int NUM_REGIONS = 16;
  localparam int NUM_EV      = 4;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_MODE     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CMD      = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LOCK     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h14;

  // command word fields
  localparam int CODE_LSB = 0;
  localparam int CODE_W   = 8;
  localparam int ARG_LSB  = 8;
  localparam int KEY_LSB  = 24;
  localparam int KEY_W    = 8;

  // command codes
  localparam logic [CODE_W-1:0] CMD_ERASE_GROUP = 8'h01;
  localparam logic [CODE_W-1:0] CMD_SET_LOCK    = 8'h02;
  localparam logic [CODE_W-1:0] CMD_CLEAR_LOCK  = 8'h03;
  localparam logic [CODE_W-1:0] CMD_GET_LOCK    = 8'h04;

  // status flags, also the interrupt event bits
  localparam int ST_READY_BIT     = 0;
  localparam int ST_CMD_ERR_BIT   = 1;
  localparam int ST_LOCK_ERR_BIT  = 2;
  localparam int ST_FLASH_ERR_BIT = 3;
  localparam int MODE_READY_IE_BIT = 0;

  // page group sizing
  localparam logic [PAGE_W-1:0] GROUP_BASE_PAGES = 16'h0004;
  localparam logic [PAGE_W-1:0] ONE_PAGE         = 16'h0001;
  localparam int GROUP_SEL_W = 2;

  localparam logic [1:0]        RESP_OKAY   = 2'h0;
  localparam logic [1:0]        RESP_SLVERR = 2'h2;
  localparam logic [STRB_W-1:0] STRB_ALL    = 4'hF;

  typedef enum logic [1:0] {
    FELS_IDLE   = 2'b00,
    FELS_CHECK  = 2'b01,
    FELS_ARRAY  = 2'b10,
    FELS_FINISH = 2'b11
  } fels_state_t;

  typedef enum logic [1:0] {
    FELS_OP_ERASE  = 2'b00,
    FELS_OP_LOCK   = 2'b01,
    FELS_OP_UNLOCK = 2'b10,
    FELS_OP_QUERY  = 2'b11
  } fels_op_t;

  typedef struct packed {
    fels_op_t          op;
    logic [PAGE_W-1:0] first_page;
    logic [PAGE_W-1:0] last_page;
  } fels_arr_req_t;

  typedef struct packed {
    fels_state_t        fsm;
    logic               aw_ok;
    logic               w_ok;
    logic [ADDR_W-1:0]  awaddr;
    logic [DATA_W-1:0]  wdata;
    logic [STRB_W-1:0]  wstrb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [DATA_W-1:0]  rdata;
    logic [1:0]         rresp;
    logic [NUM_EV-1:0]  flags;
    logic               ready_ie;
    logic [NUM_REGIONS-1:0] lock;
    logic [NUM_REGIONS-1:0] lock_result;
    fels_arr_req_t      req;
    logic               arr_valid;
    logic [NUM_EV-1:0]  ev;
  } fels_main_t;

  typedef struct packed {
    logic [NUM_EV-1:0] status;
    logic [NUM_EV-1:0] mask;
  } fels_irq_t;

endpackage

/* fels_sequencer.sv */
`timescale 1ns/1ps
// Notes on behaviour
// [RULE_01] a valid erase command word starts the erase at once
// [RULE_02] argument low two bits pick 4, 8, 16 or 32 pages
// [RULE_03] software keeps 4-page groups in small sectors, never 32 there
// [RULE_04] command_ready rises when an erase finishes
// [RULE_05] ready interrupt raised when enabled in the mode register
// [RULE_06] wrong keyword in a command write flags a command error
// [RULE_07] erase touching a locked region is refused whole with lock error
// [RULE_08] failed erase verify from the array raises flash error
// [RULE_09] each lock bit covers a region of pages, locked pages untouched
// [RULE_10] set_region_lock with a page number sets that region's bit, then ready
// [RULE_11] get_region_lock snapshots lock bits for software to read
// [RULE_12] software never names a lock bit beyond the last one
// [RULE_13] lock programming reports keyword errors and verify failures
// [RULE_14] clear_region_lock with a page number clears that bit, then ready
// [RULE_15] cleared regions accept erase again
// [RULE_16] command_ready drops on acceptance and stays low until done
module fels_sequencer
  import fels_pkg::*;
#(
  parameter logic [KEY_W-1:0] CMD_KEY      = 8'hC3,
  parameter int               REGION_SHIFT = 5
) (
  input  wire logic              CLK,
  input  wire logic              RST_B,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  input  wire logic [DATA_W-1:0] S_AXI_WDATA,
  input  wire logic [STRB_W-1:0] S_AXI_WSTRB,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  output logic      [1:0]        S_AXI_BRESP,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  output logic      [DATA_W-1:0] S_AXI_RDATA,
  output logic      [1:0]        S_AXI_RRESP,
  output fels_arr_req_t          FA_REQ,
  output logic                   FA_VALID,
  input  wire logic              FA_ACK,
  input  wire logic              FA_VERIFY_FAIL,
  output logic                   IRQ
);

  fels_main_t s;
  fels_main_t next_s;

  logic              lock_hit;
  logic [NUM_EV-1:0] irq_status;
  logic [NUM_EV-1:0] irq_mask;
  logic [NUM_EV-1:0] irq_gate;
  logic              clr_wr;
  logic              mask_wr;

  // channel readiness, one transaction of each kind in flight
  assign S_AXI_AWREADY = !s.aw_ok && !s.bvalid;
  assign S_AXI_WREADY  = !s.w_ok && !s.bvalid;
  assign S_AXI_ARREADY = !s.rvalid;

  // registered bus answers
  assign S_AXI_BVALID = s.bvalid;
  assign S_AXI_BRESP  = s.bresp;
  assign S_AXI_RVALID = s.rvalid;
  assign S_AXI_RDATA  = s.rdata;
  assign S_AXI_RRESP  = s.rresp;

  // array request held until the array acknowledges
  assign FA_REQ   = s.req;
  assign FA_VALID = s.arr_valid;

  // ready event only reaches the line when enabled in mode
  // [RULE_05] ready interrupt gate
  assign irq_gate = {{(NUM_EV-1){1'b1}}, s.ready_ie};

  // register writes that go to the interrupt unit
  assign clr_wr  = s.aw_ok && s.w_ok && !s.bvalid && (s.awaddr == OFS_IRQ_STAT) && s.wstrb[0];
  assign mask_wr = s.aw_ok && s.w_ok && !s.bvalid && (s.awaddr == OFS_IRQ_MASK) && s.wstrb[0];

  // [RULE_09] region overlap test
  fels_lock_check #(
    .REGION_SHIFT (REGION_SHIFT)
  ) u_lock_check (
    .lock       (s.lock),
    .first_page (s.req.first_page),
    .last_page  (s.req.last_page),
    .hit        (lock_hit)
  );

  fels_irq_unit u_irq (
    .clk       (CLK),
    .rst_b     (RST_B),
    .set_ev    (s.ev),
    .clr_wr    (clr_wr),
    .clr_bits  (s.wdata[NUM_EV-1:0]),
    .mask_wr   (mask_wr),
    .mask_bits (s.wdata[NUM_EV-1:0]),
    .gate      (irq_gate),
    .status    (irq_status),
    .mask      (irq_mask),
    .irq       (IRQ)
  );

  // next state: bus slave, command decode and sequencing
  always_comb begin
    logic [KEY_W-1:0]       key;
    logic [CODE_W-1:0]      code;
    logic [PAGE_W-1:0]      arg;
    logic [PAGE_W-1:0]      span;
    logic [PAGE_W-1:0]      region;
    logic [GROUP_SEL_W-1:0] sel;
    key    = s.wdata[KEY_LSB +: KEY_W];
    code   = s.wdata[CODE_LSB +: CODE_W];
    arg    = s.wdata[ARG_LSB +: PAGE_W];
    sel    = arg[GROUP_SEL_W-1:0];
    span   = (GROUP_BASE_PAGES << sel) - ONE_PAGE;
    region = s.req.first_page >> REGION_SHIFT;
    next_s    = s;
    next_s.ev = '0;

    // capture write address and data in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      next_s.aw_ok  = 1'b1;
      next_s.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      next_s.w_ok  = 1'b1;
      next_s.wdata = S_AXI_WDATA;
      next_s.wstrb = S_AXI_WSTRB;
    end

    // release answers once taken
    if (s.bvalid && S_AXI_BREADY) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && S_AXI_RREADY) begin
      next_s.rvalid = 1'b0;
    end

    // read decode, unmapped answers slverr with zero data
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      case (S_AXI_ARADDR)
        OFS_MODE: begin
          next_s.rdata = DATA_W'(s.ready_ie) << MODE_READY_IE_BIT;
        end
        OFS_CMD: begin
          next_s.rdata = '0;
        end
        OFS_STATUS: begin
          next_s.rdata = DATA_W'(s.flags);
        end
        // [RULE_11] lock snapshot readback
        OFS_LOCK: begin
          next_s.rdata = DATA_W'(s.lock_result);
        end
        OFS_IRQ_STAT: begin
          next_s.rdata = DATA_W'(irq_status);
        end
        OFS_IRQ_MASK: begin
          next_s.rdata = DATA_W'(irq_mask);
        end
        default: begin
          next_s.rdata = '0;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end

    // command sequencing
    case (s.fsm)
      FELS_IDLE: begin
        next_s.arr_valid = 1'b0;
      end
      FELS_CHECK: begin
        if (s.req.op == FELS_OP_QUERY) begin
          // [RULE_11] capture lock bits
          next_s.lock_result = s.lock;
          next_s.fsm         = FELS_FINISH;
        end else if ((s.req.op == FELS_OP_ERASE) && lock_hit) begin
          // [RULE_07] refuse whole erase
          next_s.flags[ST_LOCK_ERR_BIT] = 1'b1;
          next_s.ev[ST_LOCK_ERR_BIT]    = 1'b1;
          next_s.fsm                    = FELS_FINISH;
        end else begin
          // [RULE_15] unlocked span goes ahead
          next_s.arr_valid = 1'b1;
          next_s.fsm       = FELS_ARRAY;
        end
      end
      FELS_ARRAY: begin
        if (FA_ACK) begin
          next_s.arr_valid = 1'b0;
          next_s.fsm       = FELS_FINISH;
          // [RULE_08] verify failure from the array
          // [RULE_13] also after lock programming
          if (FA_VERIFY_FAIL) begin
            next_s.flags[ST_FLASH_ERR_BIT] = 1'b1;
            next_s.ev[ST_FLASH_ERR_BIT]    = 1'b1;
          end
          if (region < PAGE_W'(NUM_REGIONS)) begin
            // [RULE_10] set region bit
            if (s.req.op == FELS_OP_LOCK) begin
              next_s.lock[region[$clog2(NUM_REGIONS)-1:0]] = 1'b1;
            end
            // [RULE_14] clear region bit
            if (s.req.op == FELS_OP_UNLOCK) begin
              next_s.lock[region[$clog2(NUM_REGIONS)-1:0]] = 1'b0;
            end
          end
        end
      end
      FELS_FINISH: begin
        // [RULE_04] completion raises ready
        next_s.flags[ST_READY_BIT] = 1'b1;
        next_s.ev[ST_READY_BIT]    = 1'b1;
        next_s.fsm                 = FELS_IDLE;
      end
      default: begin
        next_s.fsm = FELS_IDLE;
      end
    endcase

    // write commit once both address and data are held
    if (s.aw_ok && s.w_ok && !s.bvalid) begin
      next_s.aw_ok  = 1'b0;
      next_s.w_ok   = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = RESP_OKAY;
      case (s.awaddr)
        OFS_MODE: begin
          if (s.wstrb[0]) begin
            next_s.ready_ie = s.wdata[MODE_READY_IE_BIT];
          end
        end
        OFS_CMD: begin
          // full-word write while idle is a command, else ignored
          if ((s.wstrb == STRB_ALL) && (s.fsm == FELS_IDLE)) begin
            // [RULE_16] ready and errors drop on acceptance
            next_s.flags = '0;
            if (key != CMD_KEY) begin
              // [RULE_06] bad keyword rejected
              // [RULE_13] keyword check on lock commands
              next_s.flags[ST_CMD_ERR_BIT] = 1'b1;
              next_s.ev[ST_CMD_ERR_BIT]    = 1'b1;
              next_s.fsm                   = FELS_FINISH;
            end else begin
              next_s.fsm = FELS_CHECK;
              case (code)
                // [RULE_01] erase starts on the write
                // [RULE_02] group size from low bits
                CMD_ERASE_GROUP: begin
                  next_s.req.op         = FELS_OP_ERASE;
                  next_s.req.first_page = arg & ~span;
                  next_s.req.last_page  = arg | span;
                end
                CMD_SET_LOCK: begin
                  next_s.req.op         = FELS_OP_LOCK;
                  next_s.req.first_page = arg;
                  next_s.req.last_page  = arg;
                end
                CMD_CLEAR_LOCK: begin
                  next_s.req.op         = FELS_OP_UNLOCK;
                  next_s.req.first_page = arg;
                  next_s.req.last_page  = arg;
                end
                CMD_GET_LOCK: begin
                  next_s.req.op = FELS_OP_QUERY;
                end
                default: begin
                  next_s.flags[ST_CMD_ERR_BIT] = 1'b1;
                  next_s.ev[ST_CMD_ERR_BIT]    = 1'b1;
                  next_s.fsm                   = FELS_FINISH;
                end
              endcase
            end
          end
        end
        OFS_STATUS, OFS_LOCK, OFS_IRQ_STAT, OFS_IRQ_MASK: begin
          next_s.bresp = RESP_OKAY;
        end
        default: begin
          next_s.bresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // state register, idle and ready out of reset
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      s                     <= '0;
      s.flags[ST_READY_BIT] <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

endmodule

/* fels_sequencer_assertions.sv */
`timescale 1ns/1ps
module fels_sequencer_assertions
  import fels_pkg::*;
(
  input wire logic          CLK,
  input wire logic          RST_B,
  input wire logic          S_AXI_AWVALID,
  input wire logic          S_AXI_AWREADY,
  input wire logic          S_AXI_WVALID,
  input wire logic          S_AXI_WREADY,
  input wire logic          S_AXI_BVALID,
  input wire logic          S_AXI_BREADY,
  input wire logic [1:0]    S_AXI_BRESP,
  input wire logic          S_AXI_ARVALID,
  input wire logic          S_AXI_ARREADY,
  input wire logic          S_AXI_RVALID,
  input wire logic          S_AXI_RREADY,
  input wire logic [31:0]   S_AXI_RDATA,
  input wire fels_arr_req_t FA_REQ,
  input wire logic          FA_VALID,
  input wire logic          FA_ACK
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  a_b_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
    else $error("write answer late");
  a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer dropped");
  a_aw_refuse: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken during answer");
  a_r_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer dropped");
  a_start_cause: assert property ($rose(FA_VALID) |-> $past(S_AXI_BVALID))
    else $error("array request without command");
  a_req_hold: assert property (FA_VALID && !FA_ACK |=> FA_VALID && $stable(FA_REQ))
    else $error("array request changed");
  a_ack_drop: assert property (FA_VALID && FA_ACK |=> !FA_VALID [*3])
    else $error("array request not released");
  a_group_size: assert property (FA_VALID && FA_REQ.op == FELS_OP_ERASE |->
    (FA_REQ.last_page - FA_REQ.first_page) inside {16'h0003, 16'h0007, 16'h000F, 16'h001F}
    && (FA_REQ.first_page & (FA_REQ.last_page - FA_REQ.first_page)) == 16'h0000)
    else $error("bad erase group");
  c_erase: cover property (FA_VALID && FA_ACK && FA_REQ.op == FELS_OP_ERASE);
  c_lock: cover property ($rose(FA_VALID) && FA_REQ.op == FELS_OP_LOCK);
  c_slverr: cover property (S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR);
endmodule
bind fels_sequencer fels_sequencer_assertions u_chk (
  .CLK(CLK), .RST_B(RST_B), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .FA_REQ(FA_REQ), .FA_VALID(FA_VALID), .FA_ACK(FA_ACK));

/* fels_sequencer_tb.sv */
`timescale 1ns/1ps
module fels_sequencer_tb;
  import fels_pkg::*;
  localparam logic [7:0] KEY = 8'hC3; // arbitrary keyword
  logic          CLK, RST_B, awv, wv, bready, arv, rready, fail, irq;
  logic          awrdy, wrdy, bvalid, arrdy, rvalid, fa_valid, fa_ack, fa_vf;
  logic [7:0]    aa, ra, dly;
  logic [31:0]   wd, rdata, seed, d;
  logic [1:0]    bresp, rresp, r;
  logic [15:0]   lk;
  fels_arr_req_t fa_req, cap;
  int            fail_count, total_checks, ncap, cyc;
  fels_sequencer #(.CMD_KEY(KEY)) u_dut (.CLK(CLK), .RST_B(RST_B), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awrdy), .S_AXI_AWADDR(aa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(STRB_ALL), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_ARADDR(ra), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .FA_REQ(fa_req),
    .FA_VALID(fa_valid), .FA_ACK(fa_ack), .FA_VERIFY_FAIL(fa_vf), .IRQ(irq));
  fels_flash_model u_fa (.clk(CLK), .rst_b(RST_B), .valid(fa_valid), .dly(dly), .fail(fail),
    .ack(fa_ack), .verify_fail(fa_vf));
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // capture of finished array requests, run timeout
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (fa_valid && fa_ack) begin
      cap <= fa_req;
      ncap <= ncap + 1;
    end
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge CLK);
    awv <= 1'b1; wv <= 1'b1; aa <= a; wd <= v; bready <= 1'b1;
    do begin
      @(posedge CLK);
      if (awrdy) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge CLK);
    arv <= 1'b1; ra <= a; rready <= 1'b1;
    do begin
      @(posedge CLK);
      if (arrdy) arv <= 1'b0;
    end while (!rvalid);
    v = rdata; rs = rresp;
    rready <= 1'b0;
  endtask
  task cmd(input logic [7:0] c, input logic [15:0] g, input logic [7:0] k);
    logic [31:0] e;
    int sz, ef, n0;
    bit ar;
    e = 32'h1; ar = 0; sz = 4 << g[1:0]; ef = g & ~(sz - 1); n0 = ncap;
    // expected outcome from keyword, code and lock bits
    if (k !== KEY || c == 8'h00 || c > CMD_GET_LOCK) e = 32'h3;
    else if (c == CMD_ERASE_GROUP && lk[ef >> 5]) e = 32'h5;
    else if (c != CMD_GET_LOCK) ar = 1;
    if (ar && c != CMD_ERASE_GROUP) lk[g >> 5] = (c == CMD_SET_LOCK);
    wr(OFS_CMD, {k, g, c}, r);
    chk("cmd bresp", {30'h0, r}, 32'h0);
    // array verify result, read once the stimulus has settled
    if (ar && fail) e = 32'h9;
    rd(OFS_STATUS, d, r);
    if (ar) chk("busy", {31'h0, d[0]}, 32'h0);
    while (!d[0]) rd(OFS_STATUS, d, r);
    chk("status", d, e);
    chk("array ops", 32'(ncap - n0), {31'h0, ar});
    if (ar) chk("op", {30'h0, cap.op}, {24'h0, c - 8'h01});
    if (ar && c == CMD_ERASE_GROUP) begin
      chk("first", {16'h0, cap.first_page}, 32'(ef));
      chk("last", {16'h0, cap.last_page}, 32'(ef + sz - 1));
    end
  endtask
  initial begin
    {RST_B, awv, wv, bready, arv, rready, fail} = 7'h00;
    {aa, ra, wd, dly, lk} = 72'h0;
    seed = 32'h9B0D;
    fail_count = 0; total_checks = 0;
    repeat (16) @(posedge CLK);
    RST_B <= 1'b1;
    rd(OFS_STATUS, d, r);
    chk("status reset", d, 32'h1);
    chk("rresp okay", {30'h0, r}, 32'h0);
    wr(8'h20, seed, r);
    chk("bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    rd(8'h20, d, r);
    chk("rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    // small groups kept in low pages
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      dly <= {4'h0, seed[7:4]};
      fail <= (i == 6);
      cmd(CMD_ERASE_GROUP, (i % 4 == 0) ? {12'h0, seed[3:2], 2'b00} : {7'h0, 1'b1, seed[7:2], 2'(i)}, KEY);
    end
    fail <= 1'b0;
    cmd(CMD_SET_LOCK, 16'h0047, KEY);
    cmd(CMD_GET_LOCK, 16'h0000, KEY);
    rd(OFS_LOCK, d, r);
    chk("lock bits", d, {16'h0, lk});
    cmd(CMD_ERASE_GROUP, 16'h0043, KEY);
    cmd(CMD_CLEAR_LOCK, 16'h005F, KEY);
    cmd(CMD_ERASE_GROUP, 16'h0043, KEY);
    fail <= 1'b1;
    cmd(CMD_SET_LOCK, 16'h01E0, KEY);
    fail <= 1'b0;
    cmd(CMD_ERASE_GROUP, 16'h01E1, 8'h3C);
    cmd(8'h07, 16'h0000, KEY);
    cmd(CMD_GET_LOCK, 16'h0000, KEY);
    rd(OFS_LOCK, d, r);
    chk("lock bits", d, {16'h0, lk});
    // interrupt raise, clear and gate
    wr(OFS_IRQ_STAT, 32'hF, r);
    wr(OFS_MODE, 32'h1, r);
    wr(OFS_IRQ_MASK, 32'h1, r);
    chk("irq idle", {31'h0, irq}, 32'h0);
    cmd(CMD_GET_LOCK, 16'h0000, KEY);
    chk("irq", {31'h0, irq}, 32'h1);
    rd(OFS_IRQ_STAT, d, r);
    chk("irq status", d, 32'h1);
    wr(OFS_IRQ_STAT, 32'h1, r);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    wr(OFS_MODE, 32'h0, r);
    cmd(CMD_GET_LOCK, 16'h0000, KEY);
    chk("irq gated", {31'h0, irq}, 32'h0);
    rd(OFS_IRQ_STAT, d, r);
    chk("irq status gated", d, 32'h1);
    give_verdict();
  end
endmodule
